// >>> logic/rlsw_mode_ctrl.sv
// Mode control and input routing of the eight-channel relay switch
`timescale 1ns/10ps
`include "rlsw_map.svh"

module rlsw_mode_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic limpHomeIn,
  input wire logic resetRequest_b,
  input wire logic [3:0] controlInput,
  input wire rlsw_pkg::rlsw_req_s regReq,
  output logic [15:0] regRdData,
  output logic [7:0] switchChannel,
  output logic [1:0] modeState,
  output logic irq
);
  import rlsw_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Channel, flag and register state; each has a next_ twin for the idiom
  rlsw_mode_e mode;            // Current operating mode
  rlsw_mode_e next_mode;
  rlsw_cfg_s cfg;              // Channel configuration registers
  rlsw_cfg_s next_cfg;
  logic resetFlag;             // Reset-occurred flag for software
  logic next_resetFlag;
  logic [2:0] irqStat;         // Sticky event bits
  logic [2:0] next_irqStat;
  logic [2:0] irqMask;         // Event enables
  logic [2:0] next_irqMask;
  logic [15:0] next_regRdData;
  logic [7:0] next_switchChannel;
  logic [7:0] routed;          // Per-channel command in idle mode
  logic [2:0] events;          // One-cycle event pulses
  logic softReset;             // Configuration forced to defaults
  logic limpExit;              // Last cycle of limp mode
  logic wrAllowed;             // Writes honoured outside limp mode

  // Pick one of the four control inputs by a two-bit selector
  function automatic logic pickInput(input logic [3:0] pins, input logic [1:0] sel);
    pickInput = pins[sel];
  endfunction

  // True when a request addresses the given register
  function automatic logic hit(input rlsw_req_s req, input logic [7:0] addr);
    hit = (req.addr == addr);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Channel routing

  // The selector is two bits per channel, so any pin can drive any channel
  // Each channel follows its selected pin or its software command
  generate
    for (genvar ch = 0; ch < 8; ch++) begin : gRoute
      // Pins have pull-downs, so an open pin reads low and switches off
      assign routed[ch] = cfg.inMode[ch] ?
        pickInput(controlInput, cfg.inSel[2*ch +: 2]) : cfg.onCmd[ch];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Next-state computation

  // No input reaches an output combinationally; regRdData and switchChannel are loaded from here
  // Mode, registers, flag, interrupts and outputs in one place
  always_comb begin
    next_mode = mode;
    next_cfg = cfg;
    next_resetFlag = resetFlag;
    next_irqStat = irqStat;
    next_irqMask = irqMask;
    next_regRdData = 16'h0000;
    next_switchChannel = 8'h00;
    events = 3'h0;
    limpExit = (mode == RLSW_LIMP) && !limpHomeIn;
    wrAllowed = (mode != RLSW_LIMP) && !limpHomeIn;

    // Mode transitions; the limp pin is looked at first
    if (limpHomeIn) begin
      next_mode = RLSW_LIMP;
      if (mode != RLSW_LIMP) begin
        events[`RLSW_EVT_LIMP_IN] = 1'b1;
      end
    end else if (!resetRequest_b) begin
      // Covers limp exit with the pin low as well
      next_mode = RLSW_STANDBY;
      if (mode != RLSW_STANDBY) begin
        events[`RLSW_EVT_STANDBY] = 1'b1;
      end
    end else begin
      next_mode = RLSW_IDLE;
    end
    if (limpExit) begin
      events[`RLSW_EVT_LIMP_OUT] = 1'b1;
    end

    // A write in the cycle the limp pin rises is dropped too, so no half setup survives
    // Register writes, only outside limp mode
    if (regReq.wr && wrAllowed) begin
      if (hit(regReq, `RLSW_ADDR_ONCMD)) begin
        next_cfg.onCmd = regReq.wdata[7:0];
      end
      if (hit(regReq, `RLSW_ADDR_INMODE)) begin
        next_cfg.inMode = regReq.wdata[7:0];
      end
      if (hit(regReq, `RLSW_ADDR_INSEL)) begin
        next_cfg.inSel = regReq.wdata;
      end
      if (hit(regReq, `RLSW_ADDR_IRQSTAT)) begin
        next_irqStat = irqStat & ~regReq.wdata[2:0];
      end
      if (hit(regReq, `RLSW_ADDR_IRQMASK)) begin
        next_irqMask = regReq.wdata[2:0];
      end
    end

    // The soft resets leave the interrupt registers alone so limp events stay visible
    // Defaults while limp, on limp exit, or while the reset pin is low
    softReset = limpHomeIn || limpExit || (mode == RLSW_LIMP) || !resetRequest_b;
    if (softReset) begin
      next_cfg.onCmd = `RLSW_RST_ONCMD;
      next_cfg.inMode = `RLSW_RST_INMODE;
      next_cfg.inSel = `RLSW_RST_INSEL;
    end

    // Reads stay live in limp; only the flag clear is held back there
    // Reads answer next cycle; a status read outside limp takes the flag
    if (regReq.rd) begin
      case (regReq.addr)
        `RLSW_ADDR_ONCMD: next_regRdData = {8'h00, cfg.onCmd};
        `RLSW_ADDR_INMODE: next_regRdData = {8'h00, cfg.inMode};
        `RLSW_ADDR_INSEL: next_regRdData = cfg.inSel;
        `RLSW_ADDR_STATUS: next_regRdData = {13'h0000, mode, resetFlag};
        `RLSW_ADDR_IRQSTAT: next_regRdData = {13'h0000, irqStat};
        `RLSW_ADDR_IRQMASK: next_regRdData = {13'h0000, irqMask};
        default: next_regRdData = 16'h0000;
      endcase
      if (hit(regReq, `RLSW_ADDR_STATUS) && wrAllowed) begin
        next_resetFlag = 1'b0;
      end
    end

    // Setting wins over a same-cycle clear
    if (limpExit) begin
      next_resetFlag = 1'b1;
    end
    next_irqStat = next_irqStat | events;

    // Channel drive from the present mode
    case (mode)
      RLSW_LIMP: next_switchChannel = {4'h0, controlInput};
      RLSW_STANDBY: next_switchChannel = 8'h00;
      RLSW_IDLE: next_switchChannel = routed;
      default: next_switchChannel = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State registers

  // Asynchronous clear only; the pin-driven resets above are synchronous
  // Power-on reset brings defaults, idle mode and all channels off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= RLSW_IDLE;
      cfg <= '0;
      resetFlag <= 1'b0;
      irqStat <= `RLSW_RST_IRQ;
      irqMask <= `RLSW_RST_IRQ;
      regRdData <= 16'h0000;
      switchChannel <= 8'h00;
    end else begin
      mode <= next_mode;
      cfg <= next_cfg;
      resetFlag <= next_resetFlag;
      irqStat <= next_irqStat;
      irqMask <= next_irqMask;
      regRdData <= next_regRdData;
      switchChannel <= next_switchChannel;
    end
  end

  // Kept combinational from registers only, so it cannot glitch on a pin edge
  // Level interrupt from any enabled sticky event
  assign irq = |(irqStat & irqMask);
  assign modeState = mode;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Everything here runs on the one clock; power-on reset masks the checks,
  // since outputs are forced while it is low and $past would see reset values
  default clocking cbMain @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Limp pin takes effect on the next edge
  a_limp_entry: assert property (limpHomeIn |=> mode == RLSW_LIMP)
    else $error("limp pin did not enter limp mode");

  // Configuration is back at defaults one edge later
  a_limp_cfg_cleared: assert property (limpHomeIn |=> cfg == '0)
    else $error("configuration not reset on limp");

  // Channels 1 to 4 copy the pins seen one edge earlier
  a_limp_routing: assert property (mode == RLSW_LIMP |=> switchChannel[3:0] == $past(controlInput))
    else $error("limp routing of channels 1 to 4 wrong");

  // Upper channels stay dark from the second limp cycle on
  a_limp_upper_off: assert property (mode == RLSW_LIMP ##1 mode == RLSW_LIMP
    |=> switchChannel[7:4] == 4'h0 [*1])
    else $error("channels 5 to 8 on during limp");

  // Writes during limp leave configuration and mask alone
  a_limp_ignores_writes: assert property (mode == RLSW_LIMP && regReq.wr
    |=> cfg == '0 && irqMask == $past(irqMask))
    else $error("write honoured in limp mode");

  // A set flag survives status reads while limp is active or pending
  a_limp_flag_kept: assert property ((mode == RLSW_LIMP || limpHomeIn) && resetFlag |=> resetFlag)
    else $error("reset flag cleared during limp");

  // A held reset pin cannot hold off limp mode
  a_limp_over_reset: assert property (limpHomeIn && !resetRequest_b |=> mode == RLSW_LIMP)
    else $error("reset pin beat limp pin");

  // Standby wakes straight into limp
  a_standby_wake: assert property (mode == RLSW_STANDBY && limpHomeIn |=> mode == RLSW_LIMP)
    else $error("no wake from standby into limp");

  // Reset pin alone parks the block in standby with defaults
  a_standby_entry: assert property (!resetRequest_b && !limpHomeIn
    |=> mode == RLSW_STANDBY && cfg == '0 ##1 switchChannel == 8'h00)
    else $error("reset pin did not force standby");

  // Configuration stays at defaults while the reset pin is low
  a_resetpin_cfg_default: assert property (!resetRequest_b |=> cfg == '0)
    else $error("configuration kept while reset pin low");

  // Standby never drives a channel
  a_standby_all_off: assert property (mode == RLSW_STANDBY |=> switchChannel == 8'h00)
    else $error("channel on in standby");

  // Leaving limp lands in idle or standby by the reset pin
  a_limp_exit_mode: assert property (mode == RLSW_LIMP && !limpHomeIn
    |=> cfg == '0 && mode == ($past(resetRequest_b) ? RLSW_IDLE : RLSW_STANDBY))
    else $error("wrong mode after limp");

  // Leaving limp raises the flag for software
  a_flag_after_limp: assert property (mode == RLSW_LIMP && !limpHomeIn |=> resetFlag)
    else $error("reset flag missing after limp");

  // A status read outside limp reports the flag and then clears it
  a_flag_read_clear: assert property (resetFlag && regReq.rd && regReq.addr == `RLSW_ADDR_STATUS
    && mode != RLSW_LIMP && !limpHomeIn |=> regRdData[0] && !resetFlag)
    else $error("reset flag not reported and cleared");

  // Channel 1 in pin mode follows its selected pin
  a_input_route: assert property (mode == RLSW_IDLE && cfg.inMode[0]
    |=> switchChannel[0] == $past(controlInput[cfg.inSel[1:0]]))
    else $error("channel 1 does not follow its selected pin");

  // An open or low selected pin switches channel 1 off
  a_open_pin_off: assert property (mode == RLSW_IDLE && cfg.inMode[0] && !controlInput[cfg.inSel[1:0]]
    |=> !switchChannel[0])
    else $error("channel 1 on with its selected pin low");

  // Read data stand for one cycle only, then fall back to zero
  a_rdata_one_cycle: assert property (!regReq.rd |=> regRdData == 16'h0000)
    else $error("read data outside the answer cycle");

  // Entry to limp, exit from limp and entry to standby each leave a sticky event bit; standby to idle leaves none
  a_limp_in_event: assert property (limpHomeIn && mode != RLSW_LIMP |=> irqStat[`RLSW_EVT_LIMP_IN])
    else $error("limp entry event not recorded");

  a_limp_out_event: assert property (mode == RLSW_LIMP && !limpHomeIn |=> irqStat[`RLSW_EVT_LIMP_OUT])
    else $error("limp exit event not recorded");

  a_standby_event: assert property (!limpHomeIn && !resetRequest_b && mode != RLSW_STANDBY
    |=> irqStat[`RLSW_EVT_STANDBY])
    else $error("standby entry event not recorded");

  // An enabled limp entry event raises the interrupt on the next cycle
  a_irq_level: assert property (irqMask[`RLSW_EVT_LIMP_IN] && limpHomeIn && mode != RLSW_LIMP |=> irq)
    else $error("interrupt output missing for enabled event");

endmodule

// >>> shared/rlsw_map.svh
// Register offsets, field positions and reset values of the relay switch mode block
`ifndef RLSW_MAP_SVH
`define RLSW_MAP_SVH

// Bus widths
`define RLSW_ADDR_W 8
`define RLSW_DATA_W 16

// Register byte offsets
`define RLSW_ADDR_ONCMD 8'h00
`define RLSW_ADDR_INMODE 8'h04
`define RLSW_ADDR_INSEL 8'h08
`define RLSW_ADDR_STATUS 8'h0c
`define RLSW_ADDR_IRQSTAT 8'h10
`define RLSW_ADDR_IRQMASK 8'h14

// Reset values
`define RLSW_RST_ONCMD 8'h00
`define RLSW_RST_INMODE 8'h00
`define RLSW_RST_INSEL 16'h0000
`define RLSW_RST_IRQ 3'h0

// Status register fields
`define RLSW_STAT_FLAG_BIT 0
`define RLSW_STAT_MODE_LSB 1

// Interrupt event bits
`define RLSW_EVT_LIMP_IN 0
`define RLSW_EVT_LIMP_OUT 1
`define RLSW_EVT_STANDBY 2

`endif

// >>> shared/rlsw_pkg.sv
// Types shared by the relay switch mode block
package rlsw_pkg;

  // Operating modes, Gray coded along idle-limp and idle-standby
  typedef enum logic [1:0] {
    RLSW_IDLE = 2'b00,
    RLSW_LIMP = 2'b01,
    RLSW_STANDBY = 2'b10
  } rlsw_mode_e;

  // One register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } rlsw_req_s;

  // Software-visible channel configuration
  typedef struct packed {
    logic [7:0] onCmd;
    logic [7:0] inMode;
    logic [15:0] inSel;
  } rlsw_cfg_s;

endpackage

// >>> verif/rlsw_mcu_model.sv
// Microcontroller model driving the relay switch pins and register port
`timescale 1ns/10ps
module rlsw_mcu_model (
  input wire logic clk,
  input wire logic [15:0] regRdData,
  output rlsw_pkg::rlsw_req_s regReq,
  output logic limpHomeIn,
  output logic resetRequest_b,
  output logic [3:0] controlInput
);
  import rlsw_pkg::*;
  // Pins rest where their pull-downs would leave them, reset pin released
  initial begin
    regReq = '0;
    limpHomeIn = 1'b0;
    resetRequest_b = 1'b1;
    controlInput = 4'h0;
  end
  // Pin levels change just after an edge
  task automatic setPins(input logic limp, input logic rstReq_b, input logic [3:0] ctl);
    @(posedge clk);
    limpHomeIn <= limp;
    resetRequest_b <= rstReq_b;
    controlInput <= ctl;
  endtask
  // One-cycle write strobe; the slave never stalls
  task automatic busWrite(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    regReq <= '0;
  endtask
  // Read data stand only in the cycle after the strobe, so take them there
  task automatic busRead(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'hffff};
    @(posedge clk);
    regReq <= '0;
    #1;
    d = regRdData;
  endtask
endmodule

// >>> verif/rlsw_mode_ctrl_tb_top.sv
// Self-checking bench of the relay switch mode and routing block
`timescale 1ns/10ps
`include "rlsw_map.svh"
module rlsw_mode_ctrl_tb_top;
  import rlsw_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  rlsw_req_s regReq;
  logic limpHomeIn, resetRequest_b, irq;
  logic [3:0] controlInput;
  logic [15:0] regRdData, rdVal;
  logic [7:0] switchChannel;
  logic [1:0] modeState;
  int nFail = 0;
  int checkCount = 0;
  int cycleCount = 0;
  // Rows: inMode, inSel, onCmd, pins, expected channels
  localparam logic [43:0] ROWS [5] = '{
    {8'h00, 16'h0000, 8'ha5, 4'h0, 8'ha5}, {8'hff, 16'h0000, 8'h00, 4'h1, 8'hff},
    {8'hff, 16'he4e4, 8'h00, 4'h5, 8'h55}, {8'h0f, 16'hffff, 8'hf0, 4'h7, 8'hf0},
    {8'h0f, 16'hffff, 8'h00, 4'h8, 8'h0f}};
  rlsw_mode_ctrl DUT (.clk(clk), .rst_b(rst_b), .limpHomeIn(limpHomeIn), .resetRequest_b(resetRequest_b),
    .controlInput(controlInput), .regReq(regReq), .regRdData(regRdData), .switchChannel(switchChannel),
    .modeState(modeState), .irq(irq));
  rlsw_mcu_model mcu (.clk(clk), .regRdData(regRdData), .regReq(regReq), .limpHomeIn(limpHomeIn),
    .resetRequest_b(resetRequest_b), .controlInput(controlInput));
  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Compare and close
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic giveVerdict();
    if (nFail == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Mode change plus registered output needs two edges; three gives margin
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // A hang counts as a mismatch
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 3000) begin
      nFail++;
      giveVerdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check({14'h0, modeState}, 16'h0000);
    check({8'h0, switchChannel}, 16'h0000);
    mcu.busRead(`RLSW_ADDR_STATUS, rdVal);
    check(rdVal, 16'h0000);
    mcu.busRead(8'h20, rdVal);
    check(rdVal, 16'h0000);
    // Routing table: software drive, pin select, open pin, polarity
    foreach (ROWS[i]) begin
      mcu.busWrite(`RLSW_ADDR_INMODE, {8'h0, ROWS[i][43:36]});
      mcu.busWrite(`RLSW_ADDR_INSEL, ROWS[i][35:20]);
      mcu.busWrite(`RLSW_ADDR_ONCMD, {8'h0, ROWS[i][19:12]});
      mcu.setPins(1'b0, 1'b1, ROWS[i][11:8]);
      settle();
      check({8'h0, switchChannel}, {8'h0, ROWS[i][7:0]});
      mcu.busRead(`RLSW_ADDR_INSEL, rdVal);
      check(rdVal, ROWS[i][35:20]);
      // The answer stands one cycle only, then the port falls back to zero
      @(posedge clk);
      #1;
      check(regRdData, 16'h0000);
    end
    mcu.busRead(`RLSW_ADDR_INMODE, rdVal);
    check(rdVal, 16'h000f);
    // Limp: direct routing of 1-4, 5-8 off, writes ignored, registers reset
    mcu.setPins(1'b1, 1'b1, 4'ha);
    settle();
    check({14'h0, modeState}, {14'h0, RLSW_LIMP});
    check({8'h0, switchChannel}, 16'h000a);
    mcu.busWrite(`RLSW_ADDR_ONCMD, 16'h00ff);
    mcu.setPins(1'b1, 1'b1, 4'h5);
    settle();
    check({8'h0, switchChannel}, 16'h0005);
    mcu.busRead(`RLSW_ADDR_ONCMD, rdVal);
    check(rdVal, 16'h0000);
    mcu.busRead(`RLSW_ADDR_STATUS, rdVal);
    check(rdVal, 16'h0002);
    mcu.setPins(1'b0, 1'b1, 4'hf);
    settle();
    check({14'h0, modeState}, 16'h0000);
    check({8'h0, switchChannel}, 16'h0000);
    mcu.busRead(`RLSW_ADDR_INMODE, rdVal);
    check(rdVal, 16'h0000);
    mcu.busRead(`RLSW_ADDR_STATUS, rdVal);
    check(rdVal, 16'h0001);
    mcu.busRead(`RLSW_ADDR_STATUS, rdVal);
    check(rdVal, 16'h0000);
    // Sticky events, mask, write-one-to-clear
    mcu.busRead(`RLSW_ADDR_IRQSTAT, rdVal);
    check(rdVal, 16'h0003);
    check({15'h0, irq}, 16'h0000);
    mcu.busWrite(`RLSW_ADDR_IRQMASK, 16'h0007);
    #1;
    check({15'h0, irq}, 16'h0001);
    mcu.busRead(`RLSW_ADDR_IRQMASK, rdVal);
    check(rdVal, 16'h0007);
    mcu.busWrite(`RLSW_ADDR_IRQSTAT, 16'h0003);
    #1;
    check({15'h0, irq}, 16'h0000);
    // Reset pin: standby and defaults; limp pin overrides it
    mcu.busWrite(`RLSW_ADDR_ONCMD, 16'h00ff);
    mcu.setPins(1'b0, 1'b0, 4'h0);
    settle();
    check({14'h0, modeState}, {14'h0, RLSW_STANDBY});
    check({8'h0, switchChannel}, 16'h0000);
    mcu.busRead(`RLSW_ADDR_ONCMD, rdVal);
    check(rdVal, 16'h0000);
    check({15'h0, irq}, 16'h0001);
    mcu.setPins(1'b1, 1'b0, 4'hf);
    settle();
    check({14'h0, modeState}, {14'h0, RLSW_LIMP});
    check({8'h0, switchChannel}, 16'h000f);
    mcu.setPins(1'b0, 1'b0, 4'hf);
    settle();
    check({14'h0, modeState}, {14'h0, RLSW_STANDBY});
    mcu.busRead(`RLSW_ADDR_STATUS, rdVal);
    check(rdVal, 16'h0005);
    mcu.setPins(1'b0, 1'b1, 4'h0);
    settle();
    check({14'h0, modeState}, 16'h0000);
    giveVerdict();
  end
endmodule
